//--- soft_pin_pkg.sv
package soft_pin_pkg;
   // Register indices on the plain port; the port carries the printed offsets directly.
   localparam logic [15:0] SECTION_ENABLE_ADDR = 16'h0C03;
   localparam logic [15:0] OUT_SCALE_ADDR = 16'h0C05;
   localparam logic [15:0] LOOP_SET_ADDR = 16'h0C06;
   localparam logic [15:0] XFER_TRIG_ADDR = 16'h0C07;
   localparam logic [15:0] PIN_RST_TRIG_ADDR = 16'h0C08;
   // Field positions.
   localparam int CH1_SCALE_LSB = 2;
   localparam int CH0_SCALE_LSB = 0;
   localparam int HIGH_MARGIN_BIT = 4;
   localparam int BW_LSB = 2;
   localparam int TOL_LSB = 0;
   localparam int TRIG_BIT = 0;
   localparam int ENABLE_BIT = 0;
   // Reset values.
   localparam logic [7:0] OUT_SCALE_RESET = 8'h00;
   localparam logic [7:0] LOOP_SET_RESET = 8'h00;
   localparam logic ENABLE_RESET = 1'h0;

   // Settings that reach the clock datapath, already gated by the section enable.
   typedef struct packed {
      logic [4:0] ch1_divide;           // Divide ratio for channel divider 1.
      logic [4:0] ch0_divide;           // Divide ratio for channel divider 0.
      logic high_margin_filter_select;  // High phase margin loop filter.
      logic [1:0] digital_loop_bandwidth; // Bandwidth code, 50/1/10/100 Hz.
      logic [1:0] tolerance_code;       // Reference tolerance code.
   } profile_t;
endpackage

//--- soft_pin_profile_loader.sv
`timescale 1ns/1ps
module soft_pin_profile_loader (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic rom_load_start,
   input wire logic rom_load_done,
   output logic rom_load_busy,
   output soft_pin_pkg::profile_t profile
);

   // This block keeps the soft pin settings that software writes over the plain port.
   // It hands a registered profile to the clock datapath and starts ROM downloads.
   // Both triggers share one download engine, so only one download runs at a time.
   // The engine reports the end of a download with a one-cycle done pulse.
   // Nothing here resets the register map; only the device reset does that.
   // All inputs come from logic on ref_clk, so no synchroniser is needed.

   // Stored registers.
   // Output scale register, channel 1 in bits 3:2 and channel 0 in bits 1:0.
   logic [7:0] out_scale_q;
   // Loop settings register: margin, bandwidth and tolerance fields.
   logic [7:0] loop_set_q;
   // Section enable; while low the fields above have no effect.
   logic enable_q;
   // Transfer trigger, set by software and cleared by the engine.
   logic xfer_trig_q;
   // Pin reset trigger, set by software and cleared by the engine.
   logic pin_rst_trig_q;
   // Registered read data and its next value.
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   // Address decode as named wires.
   // Each write strobe is qualified by the full address, so aliases never write.
   // Trigger writes count only when the trigger bit is one; a zero write is ignored.
   wire wr_scale = wr && (addr == soft_pin_pkg::OUT_SCALE_ADDR);
   wire wr_loop = wr && (addr == soft_pin_pkg::LOOP_SET_ADDR);
   wire wr_en = wr && (addr == soft_pin_pkg::SECTION_ENABLE_ADDR);
   wire wr_xfer = wr && (addr == soft_pin_pkg::XFER_TRIG_ADDR) &&
                  wdata[soft_pin_pkg::TRIG_BIT];
   wire wr_prst = wr && (addr == soft_pin_pkg::PIN_RST_TRIG_ADDR) &&
                  wdata[soft_pin_pkg::TRIG_BIT];

   // Busy covers both triggers because they drive one shared engine.
   // A trigger write while busy is dropped rather than queued; software polls the bit.
   // A new download starts only when none is running, so a second write is harmless.
   wire busy = xfer_trig_q || pin_rst_trig_q;
   assign rom_load_start = (wr_xfer || wr_prst) && !busy;
   assign rom_load_busy = busy;

   // Settings registers; plain storage, reserved bits are kept at zero.
   // Keeping reserved bits clear means software reads back exactly what takes effect while the section is enabled.
   // The enable register is written only through bit 0.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         out_scale_q <= soft_pin_pkg::OUT_SCALE_RESET;
         loop_set_q <= soft_pin_pkg::LOOP_SET_RESET;
         enable_q <= soft_pin_pkg::ENABLE_RESET;
      end else begin
         if (wr_scale) begin
            out_scale_q <= {4'h0, wdata[3:0]};
         end
         if (wr_loop) begin
            loop_set_q <= {3'h0, wdata[4:0]};
         end
         if (wr_en) begin
            enable_q <= wdata[soft_pin_pkg::ENABLE_BIT];
         end
      end
   end

   // Self-clearing triggers. Set wins over done when both arrive together,
   // but a set only lands while idle, so a done always ends the active one.
   // A done pulse while idle is harmless: both bits are already clear.
   // If both triggers are written together only the transfer trigger is kept.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         xfer_trig_q <= 1'h0;
         pin_rst_trig_q <= 1'h0;
      end else if (rom_load_start) begin
         xfer_trig_q <= wr_xfer;
         pin_rst_trig_q <= wr_prst && !wr_xfer;
      end else if (rom_load_done) begin
         xfer_trig_q <= 1'h0;
         pin_rst_trig_q <= 1'h0;
      end
   end

   // Scale decode, shared by both channels.
   // The ratio is handed over as a plain number so the divider needs no decode.
   function automatic logic [4:0] scale_div(input logic [1:0] code);
      case (code)
         2'h0: scale_div = 5'h01;
         2'h1: scale_div = 5'h04;
         2'h2: scale_div = 5'h08;
         2'h3: scale_div = 5'h10;
         default: scale_div = 5'h01;
      endcase
   endfunction

   // Gated fields: with the section off the datapath sees reset defaults.
   // section enable gating
   wire [7:0] scale_eff = enable_q ? out_scale_q : soft_pin_pkg::OUT_SCALE_RESET;
   wire [7:0] loop_eff = enable_q ? loop_set_q : soft_pin_pkg::LOOP_SET_RESET;

   // Register the profile so downstream dividers see glitch-free settings.
   // The profile trails a register write by one cycle, two after the strobe.
   // Reset gives divide-by-1 on both channels, the same as a disabled section.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         // Divide ratios of 1, all other fields at their reset codes.
         profile <= {5'h01, 5'h01, 1'h0, 2'h0, 2'h0};
      end else begin
         profile.ch1_divide <= scale_div(scale_eff[soft_pin_pkg::CH1_SCALE_LSB +: 2]);
         profile.ch0_divide <= scale_div(scale_eff[soft_pin_pkg::CH0_SCALE_LSB +: 2]);
         profile.high_margin_filter_select <= loop_eff[soft_pin_pkg::HIGH_MARGIN_BIT];
         profile.digital_loop_bandwidth <= loop_eff[soft_pin_pkg::BW_LSB +: 2];
         profile.tolerance_code <= loop_eff[soft_pin_pkg::TOL_LSB +: 2];
      end
   end

   // Read mux; unmapped addresses read zero.
   // Trigger bits read back so software can poll for the end of a download.
   always_comb begin
      case (addr)
         soft_pin_pkg::SECTION_ENABLE_ADDR: rdata_d = {7'h00, enable_q};
         soft_pin_pkg::OUT_SCALE_ADDR: rdata_d = out_scale_q;
         soft_pin_pkg::LOOP_SET_ADDR: rdata_d = loop_set_q;
         soft_pin_pkg::XFER_TRIG_ADDR: rdata_d = {7'h00, xfer_trig_q};
         soft_pin_pkg::PIN_RST_TRIG_ADDR: rdata_d = {7'h00, pin_rst_trig_q};
         default: rdata_d = 8'h00;
      endcase
   end

   // Read data stands one cycle after the strobe only.
   // Outside that cycle the bus reads zero, which keeps a shared bus quiet.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rd ? rdata_d : 8'h00;
      end
   end
   assign rdata = rdata_q;

   // Transfer trigger reads one after a start until done.
   property p_xfer_set;
      @(posedge ref_clk) disable iff (rst)
         (wr_xfer && !busy) |=> xfer_trig_q;
   endproperty
   a_xfer_set: assert property (p_xfer_set) else $error("transfer trigger not set");

   // A done pulse ends an active transfer trigger.
   property p_xfer_clear;
      @(posedge ref_clk) disable iff (rst)
         (xfer_trig_q && rom_load_done) |=> !xfer_trig_q;
   endproperty
   a_xfer_clear: assert property (p_xfer_clear) else $error("transfer trigger not cleared");

   // A pin reset write while idle sets its bit and busy.
   property p_prst_set;
      @(posedge ref_clk) disable iff (rst)
         (wr_prst && !wr_xfer && !busy) |=> pin_rst_trig_q && rom_load_busy;
   endproperty
   a_prst_set: assert property (p_prst_set) else $error("pin reset trigger not set");

   // A done pulse ends an active pin reset trigger.
   property p_prst_clear;
      @(posedge ref_clk) disable iff (rst)
         (pin_rst_trig_q && rom_load_done) |=> !pin_rst_trig_q;
   endproperty
   a_prst_clear: assert property (p_prst_clear) else $error("pin reset trigger not cleared");

   // A disabled section shows default channel 0 divide and tolerance.
   property p_gate;
      @(posedge ref_clk) disable iff (rst)
         !enable_q ##1 !enable_q |-> profile.ch0_divide == 5'h01 && profile.tolerance_code == 2'h0;
   endproperty
   a_gate: assert property (p_gate) else $error("fields active while disabled");

   // Channel 1 code three gives divide-by-16.
   property p_ch1;
      @(posedge ref_clk) disable iff (rst)
         enable_q && out_scale_q[3:2] == 2'h3 |=> profile.ch1_divide == 5'h10;
   endproperty
   a_ch1: assert property (p_ch1) else $error("channel 1 divide wrong");

   // Channel 0 code one gives divide-by-4.
   property p_ch0;
      @(posedge ref_clk) disable iff (rst)
         enable_q && out_scale_q[1:0] == 2'h1 |=> profile.ch0_divide == 5'h04;
   endproperty
   a_ch0: assert property (p_ch0) else $error("channel 0 divide wrong");

   // Margin and bandwidth pass through while enabled.
   property p_loop;
      @(posedge ref_clk) disable iff (rst)
         enable_q |=> profile.high_margin_filter_select == $past(loop_set_q[4]) &&
         profile.digital_loop_bandwidth == $past(loop_set_q[3:2]);
   endproperty
   a_loop: assert property (p_loop) else $error("loop settings not passed");

   // A start pulse never appears while a download runs.
   property p_start_idle;
      @(posedge ref_clk) disable iff (rst)
         rom_load_start |-> !busy;
   endproperty
   a_start_idle: assert property (p_start_idle) else $error("start while busy");

   // The two triggers are never active together.
   property p_one_trig;
      @(posedge ref_clk) disable iff (rst)
         !(xfer_trig_q && pin_rst_trig_q);
   endproperty
   a_one_trig: assert property (p_one_trig) else $error("both triggers active");

   // The transfer trigger holds until done arrives.
   property p_xfer_hold;
      @(posedge ref_clk) disable iff (rst)
         xfer_trig_q && !rom_load_done |=> xfer_trig_q;
   endproperty
   a_xfer_hold: assert property (p_xfer_hold) else $error("transfer trigger lost");

   // The pin reset trigger holds until done arrives.
   property p_prst_hold;
      @(posedge ref_clk) disable iff (rst)
         pin_rst_trig_q && !rom_load_done |=> pin_rst_trig_q;
   endproperty
   a_prst_hold: assert property (p_prst_hold) else $error("pin reset trigger lost");

   // Without a read strobe the read data are zero in the next cycle.
   property p_rdata_idle;
      @(posedge ref_clk) disable iff (rst)
         !rd |=> rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

   // A read of the scale register returns its stored value.
   property p_rdata_scale;
      @(posedge ref_clk) disable iff (rst)
         rd && addr == soft_pin_pkg::OUT_SCALE_ADDR |=> rdata == $past(out_scale_q);
   endproperty
   a_rdata_scale: assert property (p_rdata_scale) else $error("scale readback wrong");

   // Starting a download leaves the register map untouched.
   property p_map_kept;
      @(posedge ref_clk) disable iff (rst)
         rom_load_start |=> out_scale_q == $past(out_scale_q) &&
         loop_set_q == $past(loop_set_q) && enable_q == $past(enable_q);
   endproperty
   a_map_kept: assert property (p_map_kept) else $error("map changed by download");

   // Tolerance code passes through while enabled.
   property p_tol;
      @(posedge ref_clk) disable iff (rst)
         enable_q |=> profile.tolerance_code == $past(loop_set_q[1:0]);
   endproperty
   a_tol: assert property (p_tol) else $error("tolerance not passed");

   // Channel 1 code zero gives divide-by-1.
   property p_ch1_div1;
      @(posedge ref_clk) disable iff (rst)
         enable_q && out_scale_q[3:2] == 2'h0 |=> profile.ch1_divide == 5'h01;
   endproperty
   a_ch1_div1: assert property (p_ch1_div1) else $error("channel 1 divide-by-1 wrong");

   // Channel 0 code two gives divide-by-8.
   property p_ch0_div8;
      @(posedge ref_clk) disable iff (rst)
         enable_q && out_scale_q[1:0] == 2'h2 |=> profile.ch0_divide == 5'h08;
   endproperty
   a_ch0_div8: assert property (p_ch0_div8) else $error("channel 0 divide-by-8 wrong");

   // A disabled section also shows default loop fields and channel 1 divide.
   property p_gate_loop;
      @(posedge ref_clk) disable iff (rst)
         !enable_q ##1 !enable_q |-> !profile.high_margin_filter_select &&
         profile.digital_loop_bandwidth == 2'h0 && profile.ch1_divide == 5'h01;
   endproperty
   a_gate_loop: assert property (p_gate_loop) else $error("loop fields active");

   // Reserved bits of the settings registers stay clear.
   property p_rsvd;
      @(posedge ref_clk) disable iff (rst)
         out_scale_q[7:4] == 4'h0 && loop_set_q[7:5] == 3'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");

   // A write to the enable register lands in the next cycle.
   property p_en_write;
      @(posedge ref_clk) disable iff (rst)
         wr_en |=> enable_q == $past(wdata[0]);
   endproperty
   a_en_write: assert property (p_en_write) else $error("enable write lost");

   // A write to the scale register lands in the next cycle.
   property p_scale_write;
      @(posedge ref_clk) disable iff (rst)
         wr_scale |=> out_scale_q == {4'h0, $past(wdata[3:0])};
   endproperty
   a_scale_write: assert property (p_scale_write) else $error("scale write lost");

   // A write to the loop register lands in the next cycle.
   property p_loop_write;
      @(posedge ref_clk) disable iff (rst)
         wr_loop |=> loop_set_q == {3'h0, $past(wdata[4:0])};
   endproperty
   a_loop_write: assert property (p_loop_write) else $error("loop write lost");

   // Writing zero to an idle transfer trigger starts nothing.
   property p_zero_write;
      @(posedge ref_clk) disable iff (rst)
         wr && addr == soft_pin_pkg::XFER_TRIG_ADDR && !wdata[0] && !busy |=> !xfer_trig_q;
   endproperty
   a_zero_write: assert property (p_zero_write) else $error("zero write started");
endmodule

//--- soft_pin_profile_loader_tb.sv
`timescale 1ns/1ps
module soft_pin_profile_loader_tb;
   // The bench drives every port itself, always just after a rising edge.
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rom_load_done = 1'b0;
   logic [7:0] rdata;
   logic rom_load_start;
   logic rom_load_busy;
   soft_pin_pkg::profile_t profile;
   int bad_count = 0;
   int total_checks = 0;
   int cycles = 0;
   logic st; // Start pulse seen during the last write.
   // Expected divide ratio for each scale code.
   logic [4:0] div_tab [4] = '{5'h01, 5'h04, 5'h08, 5'h10};

   soft_pin_profile_loader u_dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .rom_load_start(rom_load_start),
      .rom_load_done(rom_load_done), .rom_load_busy(rom_load_busy), .profile(profile));

   initial begin
      forever #20 ref_clk = ~ref_clk;
   end

   // Hang guard; the sequence needs only about a hundred cycles.
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count = bad_count + 1;
         wrap_up();
      end
   end

   // Compares one value; unknown bits never count as a match.
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One-cycle write; the start pulse is sampled mid-cycle, where it has settled.
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d, output logic s);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(negedge ref_clk);
      s = rom_load_start;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask

   // One-cycle read; data stand only in the following cycle.
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      @(negedge ref_clk);
      chk("rdata", 16'(rdata), 16'(exp));
   endtask

   // The profile trails the register by one cycle.
   task automatic settle;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   task automatic pulse_done;
      @(posedge ref_clk);
      rom_load_done <= 1'b1;
      @(posedge ref_clk);
      rom_load_done <= 1'b0;
   endtask

   task automatic wrap_up;
      $display("Summary: %0d mismatches in %0d checks", bad_count, total_checks);
      if (bad_count == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      rd_chk(soft_pin_pkg::SECTION_ENABLE_ADDR, 8'h00);
      rd_chk(soft_pin_pkg::OUT_SCALE_ADDR, 8'h00);
      rd_chk(soft_pin_pkg::LOOP_SET_ADDR, 8'h00);
      rd_chk(soft_pin_pkg::XFER_TRIG_ADDR, 8'h00);
      rd_chk(soft_pin_pkg::PIN_RST_TRIG_ADDR, 8'h00);
      // Section still disabled: writes land but must not reach the profile.
      wr_reg(soft_pin_pkg::OUT_SCALE_ADDR, 8'hFF, st);
      wr_reg(soft_pin_pkg::LOOP_SET_ADDR, 8'hFF, st);
      settle();
      chk("profile", 16'(profile), 16'h0420);
      rd_chk(soft_pin_pkg::OUT_SCALE_ADDR, 8'h0F);
      rd_chk(soft_pin_pkg::LOOP_SET_ADDR, 8'h1F);
      wr_reg(soft_pin_pkg::SECTION_ENABLE_ADDR, 8'h01, st);
      // Every scale, bandwidth and tolerance code, channels given opposite codes.
      for (int c = 0; c < 4; c++) begin
         wr_reg(soft_pin_pkg::OUT_SCALE_ADDR, {4'h0, 2'(3 - c), 2'(c)}, st);
         wr_reg(soft_pin_pkg::LOOP_SET_ADDR, {3'h0, c[0], 2'(c), 2'(3 - c)}, st);
         settle();
         chk("profile", 16'(profile), {1'b0, div_tab[3-c], div_tab[c], c[0], 2'(c), 2'(3-c)});
      end
      // Transfer trigger, with a second trigger refused while busy.
      wr_reg(soft_pin_pkg::XFER_TRIG_ADDR, 8'h01, st);
      chk("start", 16'(st), 16'h0001);
      rd_chk(soft_pin_pkg::XFER_TRIG_ADDR, 8'h01);
      wr_reg(soft_pin_pkg::PIN_RST_TRIG_ADDR, 8'h01, st);
      chk("start", 16'(st), 16'h0000);
      pulse_done();
      @(negedge ref_clk);
      chk("busy", 16'(rom_load_busy), 16'h0000);
      rd_chk(soft_pin_pkg::XFER_TRIG_ADDR, 8'h00);
      rd_chk(soft_pin_pkg::OUT_SCALE_ADDR, 8'h03);
      // Pin reset trigger; the map must survive it.
      wr_reg(soft_pin_pkg::PIN_RST_TRIG_ADDR, 8'h01, st);
      chk("start", 16'(st), 16'h0001);
      rd_chk(soft_pin_pkg::PIN_RST_TRIG_ADDR, 8'h01);
      pulse_done();
      rd_chk(soft_pin_pkg::PIN_RST_TRIG_ADDR, 8'h00);
      rd_chk(soft_pin_pkg::LOOP_SET_ADDR, 8'h1C);
      wr_reg(soft_pin_pkg::XFER_TRIG_ADDR, 8'h00, st);
      chk("start", 16'(st), 16'h0000);
      rd_chk(16'h0C09, 8'h00);
      wrap_up();
   end
endmodule
